// *** lpg_pkg.sv ***
// lpg_pkg: shared constants for the line driver power guard
// assumes a single 125 MHz system clock and an APB register port
`default_nettype none
package lpg_pkg;
  // clocking and sample rate
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned SAMPLE_RATE_HZ = 800;
  localparam int unsigned SAMPLE_DIV     = 1_000_000_000 / (CLK_PERIOD_NS * SAMPLE_RATE_HZ);

  // datapath widths and scaling
  localparam int unsigned DW             = 16;
  localparam int unsigned NQ             = 6;
  localparam int unsigned POLE_FRAC      = 12;
  localparam logic [12:0] POLE_MAX       = 13'h1000;
  localparam int unsigned POLE_SIGN_BIT  = 15;
  // 0.75 V in converter codes of 4.907 mV
  localparam logic [15:0] VCE_OFFSET     = 16'h0099;
  // product lsb 15.2 nW: 498 uW scale and 31.4 uW scale
  localparam int unsigned SHIFT_COARSE   = 15;
  localparam int unsigned SHIFT_FINE     = 11;

  // register byte offsets
  localparam logic [7:0] OFS_SUM         = 8'h00;
  localparam logic [7:0] OFS_LIM12       = 8'h04;
  localparam logic [7:0] OFS_LIM34       = 8'h08;
  localparam logic [7:0] OFS_LIM56       = 8'h0C;
  localparam logic [7:0] OFS_POLE12      = 8'h10;
  localparam logic [7:0] OFS_POLE34      = 8'h14;
  localparam logic [7:0] OFS_POLE56      = 8'h18;
  localparam logic [7:0] OFS_PEND        = 8'h1C;
  localparam logic [7:0] OFS_ENAB        = 8'h20;
  localparam logic [7:0] OFS_CTRL        = 8'h24;
  localparam logic [7:0] OFS_LINE        = 8'h28;
  localparam logic [7:0] OFS_DIE         = 8'h2C;

  // field positions
  localparam int unsigned CTRL_INTEG_BIT = 0;
  localparam int unsigned CTRL_TSEL_BIT  = 1;
  localparam int unsigned LINE_REQ_BIT   = 0;
  localparam int unsigned LINE_FORCE_BIT = 8;
  localparam int unsigned DIE_STAT_BIT   = 0;

  // reset values
  localparam logic [15:0] RST_LIMIT      = 16'hFFFF;
  localparam logic [15:0] RST_POLE       = 16'h0000;
endpackage
`default_nettype wire

// *** lpg_thermal_lpf.sv ***
// lpg_thermal_lpf: first order low-pass modelling package heating
// assumes update is a one-cycle pulse on the 800 Hz calculation rate
`default_nettype none
module lpg_thermal_lpf
  import lpg_pkg::*;
#(
  parameter int unsigned W = lpg_pkg::DW
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         update,
  input  wire logic [W-1:0] sample,
  input  wire logic [15:0]  pole,
  output logic      [W-1:0] filtered
);
  localparam int unsigned AW = W + POLE_FRAC;
  localparam int unsigned DWD = AW + 2;
  localparam int unsigned PW = DWD + 14;

  logic        [AW-1:0]  acc;
  logic        [12:0]    mag;
  logic signed [DWD-1:0] diff;
  logic signed [PW-1:0]  prod;
  logic signed [DWD-1:0] step;
  logic        [DWD-1:0] next_acc;

  ////////////////////////////////////////////////////////////////////////
  // sign-magnitude pole: negative blocks, magnitude clamped to full scale
  always_comb begin
    if (pole[POLE_SIGN_BIT]) begin
      mag = '0;
    end else if (pole[12:0] > POLE_MAX) begin
      mag = POLE_MAX;
    end else begin
      mag = pole[12:0];
    end
    diff     = $signed({2'b00, sample, {POLE_FRAC{1'b0}}}) - $signed({2'b00, acc});
    prod     = diff * $signed({1'b0, mag});
    step     = DWD'(prod >>> POLE_FRAC);
    next_acc = DWD'($signed({2'b00, acc}) + step);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc <= '0;
    end else if (update) begin
      acc <= next_acc[AW-1:0];
    end
  end

  assign filtered = acc[AW-1:POLE_FRAC];
endmodule
`default_nettype wire

// *** lpg_power_guard.sv ***
// lpg_power_guard: per-channel linefeed transistor power monitor
// assumes sense samples come from logic on clk_sys; overtemp pin is asynchronous
//
// Functional notes
// - integrated driver: Q1-Q2 power is (lead voltage + 0.75 V) times current, Q3-Q4 (battery + 0.75 V); Q5-Q6 battery-minus-lead.
// - the six estimates are summed into total_power_sum, readable by software.
// - every power value is low-pass filtered at the 800 Hz calculation rate before comparison.
// - pole locations hold 13-bit magnitude plus sign, largest value 4096.
// - pair three-four limit is 16-bit, 0 to 1.03 W, 31.4 uW steps.
// - sum and the other two limits are 16-bit, 0 to 16.319 W, 498 uW steps.
// - discrete mode filters and compares each pair with its own pole and limit.
// - integrated mode compares only the filtered sum and alarms when it exceeds its limit.
// - integrated mode takes limit and pole from the pair one-two locations.
// - driver overtemp (with sense select set), transistor alarm or total alarm forces the line open.
// - forced open holds until software writes the line state register, masked or not.
// - one pending and one enable bit per transistor; enable gates the interrupt.
// - integrated mode uses only the first pending and enable bit.
// - pending bit sets on comparator rising edge, holds until software clears it.
// - with sense select set, driver overtemp shuts driver and sets die status.
`default_nettype none
module lpg_power_guard
  import lpg_pkg::*;
#(
  parameter int unsigned SAMPLE_DIV_P = lpg_pkg::SAMPLE_DIV
) (
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [DW-1:0] v_tip,
  input  wire logic [DW-1:0] v_ring,
  input  wire logic [DW-1:0] v_bat,
  input  wire logic [DW-1:0] i_q1,
  input  wire logic [DW-1:0] i_q2,
  input  wire logic [DW-1:0] i_q3,
  input  wire logic [DW-1:0] i_q4,
  input  wire logic [DW-1:0] i_q5,
  input  wire logic [DW-1:0] i_q6,
  input  wire logic          driver_overtemp,
  output logic               driver_shutdown,
  output logic               line_open,
  output logic               power_alarm_irq,
  output logic               sample_tick
);
  import lpg_pkg::*;

  if (SAMPLE_DIV_P < 4) begin : g_div_check
    $error("SAMPLE_DIV_P must be at least 4");
  end

  localparam int unsigned CW = $clog2(SAMPLE_DIV_P);

  logic [CW-1:0]   div_cnt;
  logic            tick;
  logic [DW-1:0]   total_power_sum;
  logic [DW-1:0]   lim12, lim34, lim56;
  logic [DW-1:0]   pole12, pole34, pole56;
  logic [NQ-1:0]   transistor_alarm_pending;
  logic [NQ-1:0]   transistor_alarm_enable;
  logic            integ_mode;
  logic            thermal_sense_select;
  logic            open_request;
  logic            forced_open;
  logic            die_status;
  logic            ot_meta, ot_sync, ot_prev;
  logic [DW:0]     vce [NQ];
  logic [DW-1:0]   iq  [NQ];
  logic [DW-1:0]   pq  [NQ];
  logic [DW-1:0]   filt_in [NQ];
  logic [DW-1:0]   filt_out [NQ];
  logic [15:0]     pole_sel [NQ];
  logic [DW-1:0]   lim_sel [NQ];
  logic [35:0]     next_sum;
  logic [DW-1:0]   next_total_power_sum;
  logic            calc_valid, cmp_valid;
  logic [NQ-1:0]   cmp, rise;
  logic            wr_en, rd_en, addr_ok;
  logic            line_write, ot_event, alarm_event;

  function automatic logic [DW-1:0] sat16(input logic [35:0] x);
    sat16 = (|x[35:DW]) ? '1 : x[DW-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // 800 Hz calculation enable
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= '0;
    end else if (div_cnt == CW'(SAMPLE_DIV_P - 1)) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign tick        = (div_cnt == CW'(SAMPLE_DIV_P - 1));
  assign sample_tick = tick;

  ////////////////////////////////////////////////////////////////////////
  // per-transistor power estimates
  always_comb begin
    vce[0] = {1'b0, v_tip}  + {1'b0, VCE_OFFSET};
    vce[1] = {1'b0, v_ring} + {1'b0, VCE_OFFSET};
    vce[2] = {1'b0, v_bat}  + {1'b0, VCE_OFFSET};
    vce[3] = {1'b0, v_bat}  + {1'b0, VCE_OFFSET};
    vce[4] = (v_bat > v_ring) ? {1'b0, v_bat - v_ring} : '0;
    vce[5] = (v_bat > v_tip)  ? {1'b0, v_bat - v_tip}  : '0;
    iq[0] = i_q1;
    iq[1] = i_q2;
    iq[2] = i_q3;
    iq[3] = i_q4;
    iq[4] = i_q5;
    iq[5] = i_q6;
  end

  logic [32:0] prod [NQ];
  genvar gi;
  for (gi = 0; gi < NQ; gi++) begin : g_q
    localparam int unsigned SH = (gi == 2 || gi == 3) ? SHIFT_FINE : SHIFT_COARSE;
    assign prod[gi] = vce[gi] * iq[gi];
    assign pq[gi]   = sat16(36'(prod[gi] >> SH));
    // pair index: 0 for Q1/Q2, 1 for Q3/Q4, 2 for Q5/Q6
    localparam int unsigned PAIR = gi / 2;
    always_comb begin
      if (integ_mode && gi == 0) begin
        filt_in[gi]  = total_power_sum;
        pole_sel[gi] = pole12;
        lim_sel[gi]  = lim12;
      end else begin
        filt_in[gi]  = pq[gi];
        pole_sel[gi] = (PAIR == 0) ? pole12 : (PAIR == 1) ? pole34 : pole56;
        lim_sel[gi]  = (PAIR == 0) ? lim12  : (PAIR == 1) ? lim34  : lim56;
      end
    end
    lpg_thermal_lpf #(.W(DW)) u_lpf (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .update   (calc_valid),
      .sample   (filt_in[gi]),
      .pole     (pole_sel[gi]),
      .filtered (filt_out[gi])
    );
  end

  always_comb begin
    next_sum = '0;
    for (int k = 0; k < NQ; k++) begin
      next_sum = next_sum + 36'(prod[k]);
    end
    next_total_power_sum = sat16(next_sum >> SHIFT_COARSE);
  end

  ////////////////////////////////////////////////////////////////////////
  // calculation pipeline: sum, filter, compare
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      total_power_sum <= '0;
      calc_valid      <= 1'b0;
      cmp_valid       <= 1'b0;
    end else begin
      calc_valid <= tick;
      cmp_valid  <= calc_valid;
      if (tick) begin
        total_power_sum <= next_total_power_sum;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmp  <= '0;
      rise <= '0;
    end else if (cmp_valid) begin
      for (int k = 0; k < NQ; k++) begin
        if (integ_mode && k != 0) begin
          cmp[k]  <= 1'b0;
          rise[k] <= 1'b0;
        end else begin
          cmp[k]  <= filt_out[k] > lim_sel[k];
          rise[k] <= (filt_out[k] > lim_sel[k]) && !cmp[k];
        end
      end
    end else begin
      rise <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // driver overtemp pin
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ot_meta <= 1'b0;
      ot_sync <= 1'b0;
      ot_prev <= 1'b0;
    end else begin
      ot_meta <= driver_overtemp;
      ot_sync <= ot_meta;
      ot_prev <= ot_sync;
    end
  end
  assign ot_event        = thermal_sense_select && ot_sync && !ot_prev;
  assign driver_shutdown = thermal_sense_select && ot_sync;

  ////////////////////////////////////////////////////////////////////////
  // apb slave
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign pready  = 1'b1;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= OFS_DIE);
  assign pslverr = psel && penable && !addr_ok;
  assign line_write = wr_en && (paddr == OFS_LINE);
  assign alarm_event = |rise;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lim12  <= RST_LIMIT;
      lim34  <= RST_LIMIT;
      lim56  <= RST_LIMIT;
      pole12 <= RST_POLE;
      pole34 <= RST_POLE;
      pole56 <= RST_POLE;
      transistor_alarm_enable <= '0;
      integ_mode              <= 1'b0;
      thermal_sense_select    <= 1'b0;
      open_request            <= 1'b0;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_LIM12:  lim12  <= pwdata[DW-1:0];
        OFS_LIM34:  lim34  <= pwdata[DW-1:0];
        OFS_LIM56:  lim56  <= pwdata[DW-1:0];
        OFS_POLE12: pole12 <= pwdata[15:0];
        OFS_POLE34: pole34 <= pwdata[15:0];
        OFS_POLE56: pole56 <= pwdata[15:0];
        OFS_ENAB:   transistor_alarm_enable <= pwdata[NQ-1:0];
        OFS_CTRL: begin
          integ_mode           <= pwdata[CTRL_INTEG_BIT];
          thermal_sense_select <= pwdata[CTRL_TSEL_BIT];
        end
        OFS_LINE:   open_request <= pwdata[LINE_REQ_BIT];
        default: ;
      endcase
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      transistor_alarm_pending <= '0;
    end else begin
      transistor_alarm_pending <= (transistor_alarm_pending &
                                   ~((wr_en && paddr == OFS_PEND) ? pwdata[NQ-1:0] : '0)) | rise;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      forced_open <= 1'b0;
    end else if (alarm_event || ot_event) begin
      forced_open <= 1'b1;
    end else if (line_write) begin
      forced_open <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      die_status <= 1'b0;
    end else if (ot_event) begin
      die_status <= 1'b1;
    end else if (wr_en && paddr == OFS_DIE && pwdata[DIE_STAT_BIT]) begin
      die_status <= 1'b0;
    end
  end

  assign line_open       = open_request || forced_open;
  assign power_alarm_irq = |(transistor_alarm_pending & transistor_alarm_enable);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata <= '0;
    end else if (rd_en && !penable) begin
      prdata <= '0;
      unique case (paddr)
        OFS_SUM:    prdata[DW-1:0] <= total_power_sum;
        OFS_LIM12:  prdata[DW-1:0] <= lim12;
        OFS_LIM34:  prdata[DW-1:0] <= lim34;
        OFS_LIM56:  prdata[DW-1:0] <= lim56;
        OFS_POLE12: prdata[15:0]   <= pole12;
        OFS_POLE34: prdata[15:0]   <= pole34;
        OFS_POLE56: prdata[15:0]   <= pole56;
        OFS_PEND:   prdata[NQ-1:0] <= transistor_alarm_pending;
        OFS_ENAB:   prdata[NQ-1:0] <= transistor_alarm_enable;
        OFS_CTRL: begin
          prdata[CTRL_INTEG_BIT] <= integ_mode;
          prdata[CTRL_TSEL_BIT]  <= thermal_sense_select;
        end
        OFS_LINE: begin
          prdata[LINE_REQ_BIT]   <= open_request;
          prdata[LINE_FORCE_BIT] <= forced_open;
        end
        OFS_DIE:    prdata[DIE_STAT_BIT] <= die_status;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  a_tick_spacing: assert property (@(posedge clk_sys) disable iff (!rstn)
    tick |=> !tick ##1 !tick ##1 !tick) else $error("calculation ticks too close");
  a_sum_update: assert property (@(posedge clk_sys) disable iff (!rstn)
    tick |=> total_power_sum == $past(next_total_power_sum)) else $error("power sum not updated");
  a_compare_strict: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmp_valid && !integ_mode |=> cmp[2] == ($past(filt_out[2]) > $past(lim34))) else $error("pair limit compare wrong");
  a_pending_rise: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmp_valid && (filt_out[0] > lim_sel[0]) && !cmp[0] |=> ##1 transistor_alarm_pending[0])
    else $error("pending bit missed rising alarm");
  a_integ_bit0: assert property (@(posedge clk_sys) disable iff (!rstn)
    integ_mode && cmp_valid |=> cmp[NQ-1:1] == '0) else $error("upper alarms active in integrated mode");
  a_integ_source: assert property (@(posedge clk_sys) disable iff (!rstn)
    integ_mode |-> filt_in[0] == total_power_sum && lim_sel[0] == lim12) else $error("sum path wrong");
  a_force_open: assert property (@(posedge clk_sys) disable iff (!rstn)
    |rise |=> line_open ##1 (line_open || $past(line_write))) else $error("line not forced open");
  a_open_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    forced_open && !line_write |=> forced_open) else $error("forced open released early");
  a_irq_masked: assert property (@(posedge clk_sys) disable iff (!rstn)
    transistor_alarm_enable == '0 |-> !power_alarm_irq) else $error("masked alarm interrupts");
  a_overtemp_shut: assert property (@(posedge clk_sys) disable iff (!rstn)
    thermal_sense_select && $rose(ot_sync) |=> die_status && forced_open) else $error("overtemp not handled");
endmodule
`default_nettype wire

// *** lpg_sense_model.sv ***
// lpg_sense_model: behavioural linefeed sense path and driver thermometer
// assumes clk_sys and rstn from the bench; sense codes held steady between samples
`default_nettype none
module lpg_sense_model (
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  input  wire logic                  hot,
  output logic      [lpg_pkg::DW-1:0] v_tip,
  output logic      [lpg_pkg::DW-1:0] v_ring,
  output logic      [lpg_pkg::DW-1:0] v_bat,
  output logic      [lpg_pkg::DW-1:0] i_q1,
  output logic      [lpg_pkg::DW-1:0] i_q2,
  output logic      [lpg_pkg::DW-1:0] i_q3,
  output logic      [lpg_pkg::DW-1:0] i_q4,
  output logic      [lpg_pkg::DW-1:0] i_q5,
  output logic      [lpg_pkg::DW-1:0] i_q6,
  output logic                       driver_overtemp
);
  timeunit 1ns;
  timeprecision 1ps;
  import lpg_pkg::*;

  // with the offset, tip and ring land on 2^15 codes and battery on 2^16
  assign v_tip  = 16'h7F67;
  assign v_ring = 16'h7F67;
  assign v_bat  = 16'hFF67;
  assign i_q1   = 16'h0002;
  assign i_q2   = 16'h0003;
  assign i_q3   = 16'h0004;
  assign i_q4   = 16'h0005;
  assign i_q5   = 16'h0006;
  assign i_q6   = 16'h0007;

  // thermometer trips when told to
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      driver_overtemp <= 1'b0;
    end else begin
      driver_overtemp <= hot;
    end
  end
endmodule
`default_nettype wire

// *** lpg_testbench.sv ***
// lpg_testbench: self-checking bench for the line driver power guard
// assumes lpg_pkg, lpg_power_guard and lpg_sense_model are compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import lpg_pkg::*;

  localparam int unsigned DIV = 8;
  logic          clk_sys, rstn, psel, penable, pwrite, hot;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata;
  logic          pready, pslverr;
  logic [DW-1:0] v_tip, v_ring, v_bat, i_q1, i_q2, i_q3, i_q4, i_q5, i_q6;
  logic          driver_overtemp, driver_shutdown, line_open, power_alarm_irq, sample_tick;
  int            bad_count = 0;
  int            comparisons = 0;

  lpg_sense_model i_lpg_sense_model (.clk_sys(clk_sys), .rstn(rstn), .hot(hot), .v_tip(v_tip),
    .v_ring(v_ring), .v_bat(v_bat), .i_q1(i_q1), .i_q2(i_q2), .i_q3(i_q3), .i_q4(i_q4),
    .i_q5(i_q5), .i_q6(i_q6), .driver_overtemp(driver_overtemp));

  lpg_power_guard #(.SAMPLE_DIV_P(DIV)) i_lpg_power_guard (.clk_sys(clk_sys), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .v_tip(v_tip), .v_ring(v_ring),
    .v_bat(v_bat), .i_q1(i_q1), .i_q2(i_q2), .i_q3(i_q3), .i_q4(i_q4), .i_q5(i_q5),
    .i_q6(i_q6), .driver_overtemp(driver_overtemp), .driver_shutdown(driver_shutdown),
    .line_open(line_open), .power_alarm_irq(power_alarm_irq), .sample_tick(sample_tick));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s is %h, want %h", $time, what, got, exp);
    end
  endtask

  task automatic timed_out(input string what);
    bad_count++;
    $display("unexpected at %0t: no %s", $time, what);
    wrap_up();
  endtask

  // one transfer, setup then access until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      timed_out("pready");
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0, "write error");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, what);
  endtask

  // let k samples pass, then the alarm pipeline settle
  task automatic wait_tick(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (sample_tick !== 1'b1 && n < 4 * DIV);
      if (n >= 4 * DIV) begin
        timed_out("sample tick");
      end
    end
    repeat (4) @(posedge clk_sys);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    logic [7:0]  ofs [6] = '{OFS_LIM12, OFS_LIM34, OFS_LIM56, OFS_POLE12, OFS_POLE34, OFS_POLE56};
    logic [15:0] val [6] = '{16'h0480, 16'h2600, 16'h1B80, 16'h0100, 16'h0100, 16'h0010};
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 6; i++) begin
      rd_chk(ofs[i], {16'h0, i < 3 ? RST_LIMIT : RST_POLE}, "reset value");
    end
    for (int i = 0; i < 6; i++) begin
      wr(ofs[i], {16'h0, val[i]});
    end
    for (int i = 0; i < 6; i++) begin
      rd_chk(ofs[i], {16'h0, val[i]}, "readback");
    end
    wr(OFS_POLE56, 32'h0000_1000);
    rd_chk(OFS_POLE56, 32'h0000_1000, "largest pole");
    wr(OFS_POLE34, 32'h0000_8100);
    rd_chk(OFS_POLE34, 32'h0000_8100, "signed pole");
    wr(OFS_SUM, 32'h0000_5A5A);
    rd_chk(OFS_SUM, 32'h0000_0024, "read-only sum");
    apb(1'b0, 8'h30, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    $display("test regs done");
  endtask

  task automatic test_alarm();
    wr(OFS_CTRL, 32'h0);
    wr(OFS_POLE12, 32'h0000_1000);
    wr(OFS_POLE34, 32'h0000_1000);
    wr(OFS_POLE56, 32'h0000_1000);
    wr(OFS_LIM12, 32'h0000_0002);
    wr(OFS_LIM34, 32'h0000_0080);
    wr(OFS_LIM56, 32'h0000_0006);
    wr(OFS_ENAB, 32'h0000_003F);
    wait_tick(2);
    rd_chk(OFS_PEND, 32'h0000_002A, "pair alarms");
    chk({31'h0, line_open}, 32'h1, "forced open");
    chk({31'h0, power_alarm_irq}, 32'h1, "irq");
    wr(OFS_ENAB, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, power_alarm_irq}, 32'h0, "masked irq");
    wr(OFS_PEND, 32'h0000_003F);
    wait_tick(2);
    rd_chk(OFS_PEND, 32'h0, "cleared pending");
    chk({31'h0, line_open}, 32'h1, "held open");
    wr(OFS_LINE, 32'h0);
    wait_tick(1);
    chk({31'h0, line_open}, 32'h0, "line released");
    $display("test alarm done");
  endtask

  task automatic test_integrated();
    wr(OFS_LIM12, 32'h0000_0024);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_LIM34, 32'h0);
    wr(OFS_LIM56, 32'h0);
    wr(OFS_ENAB, 32'h1);
    wait_tick(2);
    rd_chk(OFS_SUM, 32'h0000_0024, "sum");
    rd_chk(OFS_PEND, 32'h0, "sum at limit");
    wr(OFS_LIM12, 32'h0000_0023);
    wait_tick(2);
    rd_chk(OFS_PEND, 32'h1, "sum alarm");
    chk({31'h0, power_alarm_irq}, 32'h1, "sum irq");
    chk({31'h0, line_open}, 32'h1, "sum open");
    $display("test integrated done");
  endtask

  task automatic test_overtemp();
    wr(OFS_PEND, 32'h0000_003F);
    wr(OFS_LINE, 32'h0);
    hot <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk({31'h0, driver_shutdown}, 32'h0, "unselected shutdown");
    chk({31'h0, line_open}, 32'h0, "unselected open");
    hot <= 1'b0;
    repeat (6) @(posedge clk_sys);
    wr(OFS_CTRL, 32'h3);
    hot <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk({31'h0, driver_shutdown}, 32'h1, "shutdown");
    chk({31'h0, line_open}, 32'h1, "overtemp open");
    rd_chk(OFS_DIE, 32'h1, "die status");
    wr(OFS_DIE, 32'h1);
    rd_chk(OFS_DIE, 32'h0, "die cleared");
    wr(OFS_LINE, 32'h1);
    rd_chk(OFS_LINE, 32'h1, "open request");
    chk({31'h0, line_open}, 32'h1, "requested open");
    hot <= 1'b0;
    $display("test overtemp done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hot = 1'b0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    test_regs();
    test_alarm();
    test_integrated();
    test_overtemp();
    wrap_up();
  end
endmodule
`default_nettype wire
